/* common/qwud_pkg.sv */
package qwud_pkg;

  // ==========================================================================
  // Array geometry
  localparam int unsigned NUM_WIPERS = 4;
  localparam int unsigned POS_W      = 8;
  localparam int unsigned NUM_TAPS   = 256;
  localparam int unsigned ROW_W      = 2;
  localparam int unsigned MEM_AW     = 4;
  localparam int unsigned SYNC_W     = 10;

  localparam logic [POS_W-1:0]    POS_MIN  = 8'h00;
  localparam logic [POS_W-1:0]    POS_MAX  = 8'hFF;
  localparam logic [POS_W-1:0]    POS_STEP = 8'h01;
  localparam logic [NUM_TAPS-1:0] TAP_LOW  = {{(NUM_TAPS-1){1'b0}}, 1'b1};
  localparam logic [ROW_W-1:0]    ROW_DEF  = 2'h0;
  localparam logic [POS_W-1:0]    MEM_INIT = 8'h00;

  // ==========================================================================
  // Two-wire register map and slave address
  localparam logic [7:0] ADDR_STATUS   = 8'h07;
  localparam logic [7:0] ADDR_DCP_LAST = 8'h03;
  localparam logic [2:0] SR_RESET      = 3'h0;
  localparam int unsigned SR_NV_BIT    = 0;
  localparam int unsigned SR_ROW_LO    = 1;
  localparam int unsigned SR_ROW_HI    = 2;
  // Arbitrary neutral device type value.
  localparam logic [3:0] TYPE_ID_DEF   = 4'hA;
  localparam logic [3:0] BYTE_BITS     = 4'h8;
  localparam logic [2:0] RECALL_END    = 3'h4;

  // ==========================================================================
  // Timing
  localparam int unsigned CLK_PERIOD_NS = 4;
  localparam int unsigned T_NV_WRITE_MS = 5;
  localparam int unsigned NV_WRITE_CYC  = T_NV_WRITE_MS * 1000000 / CLK_PERIOD_NS;
  localparam int unsigned BUSY_W        = 21;

  typedef enum logic [3:0] {
    S_IDLE   = 4'b0000,
    S_DEV    = 4'b0001,
    S_DEVACK = 4'b0010,
    S_REG    = 4'b0011,
    S_REGACK = 4'b0100,
    S_WR     = 4'b0101,
    S_WRACK  = 4'b0110,
    S_RD     = 4'b0111,
    S_RDACK  = 4'b1000
  } qwud_state_t;

endpackage

/* design/qwud_sync.sv */
module qwud_sync #(
  parameter int unsigned W = 1
) (
  input  wire logic         i_clk,
  input  wire logic         i_rst,
  input  wire logic [W-1:0] i_d,
  output logic      [W-1:0] o_q
);

  // ==========================================================================
  // Two-stage synchroniser, idle-high reset to match released bus lines.
  logic [W-1:0] meta_r;

  for (genvar b = 0; b < W; b++) begin : g_bit
    always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
        meta_r[b] <= 1'b1;
        o_q[b]    <= 1'b1;
      end else begin
        meta_r[b] <= i_d[b];
        o_q[b]    <= meta_r[b];
      end
    end
  end

endmodule // qwud_sync

/* design/qwud_nvmem.sv */
module qwud_nvmem #(
  parameter int unsigned       DW   = 8,
  parameter int unsigned       AW   = 4,
  parameter logic [DW-1:0]     INIT = '0
) (
  input  wire logic          i_clk,
  input  wire logic          i_we,
  input  wire logic [AW-1:0] i_addr,
  input  wire logic [DW-1:0] i_wdata,
  output logic      [DW-1:0] o_rdata
);

  // ==========================================================================
  // Saved positions: not cleared by reset, so they survive a power cycle.
  logic [DW-1:0] mem [2**AW];

  initial begin
    for (int i = 0; i < 2**AW; i++) begin
      mem[i] = INIT;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_we) begin
      mem[i_addr] <= i_wdata;
    end
    o_rdata <= mem[i_addr];
  end

endmodule // qwud_nvmem

/* design/qwud_top.sv */
// Overview of operation
// - Each 8-bit wiper position decodes to exactly one of 256 tap enables.
// - Position zero selects the low-end tap, all ones the high-end tap.
// - Each wiper has a writable position plus four readable, writable saved registers.
// - At power-up each position loads from its saved register row zero.
// - With chip select low, clock falling edges count up or down per direction.
// - Two channel select inputs pick the counted wiper as a binary index.
// - Chip select rising with clock and write-protect high stores position to row zero.
// - Chip select rising with clock low returns to standby without storing.
// - Chip select rising with clock high but write-protect low stores nothing.
// - Direction may change any time; two-wire bus ignored while chip select low.
// - Device is a slave; transfers start with START, address byte, MSB first.
// - START is data falling, STOP data rising, both with clock high.
// - Data pin stays released after power-up until a response is required.
// - Address byte holds type id, three pin-matched bits and a read flag.
// - Device acknowledges a matching address and every written byte.
// - Transmitter releases data after eight bits; receiver pulls low on ninth.
// - Read sends eight bits, continues on acknowledge, stops without one.
// - STOP after a read returns the device to standby.
// - After a saved-register write's STOP, a self-timed 5 ms cycle blocks commands.
// - Address is not acknowledged while the internal write is busy.
// - Status register at 07h resets to 00h; bits 2:1 row, bit 0 saved select.
module qwud_top #(
  parameter int unsigned P_NV_WRITE_CYC = qwud_pkg::NV_WRITE_CYC,
  parameter logic [3:0]  P_TYPE_ID      = qwud_pkg::TYPE_ID_DEF
) (
  input  wire logic                                            i_sys_clk,
  input  wire logic                                            i_rst,
  input  wire logic                                            i_cs_n,
  input  wire logic                                            i_scl,
  input  wire logic                                            i_sda,
  output logic                                                 o_sda_out,
  output logic                                                 o_sda_oe,
  input  wire logic                                            i_updown,
  input  wire logic                                            i_channel_sel_lsb,
  input  wire logic                                            i_channel_sel_msb,
  input  wire logic                                            i_wp_n,
  input  wire logic                                            i_addr_pin_0,
  input  wire logic                                            i_addr_pin_1,
  input  wire logic                                            i_addr_pin_2,
  output logic [qwud_pkg::NUM_WIPERS-1:0][qwud_pkg::NUM_TAPS-1:0] o_tap_en,
  output logic                                                 o_nv_busy
);
  import qwud_pkg::*;
  // ==========================================================================
  // Input synchronisation and edge detection
  logic [SYNC_W-1:0] sy;
  logic scl_s, sda_s, cs_s, up_s, wp_s;
  logic [1:0] sel_w;
  logic [2:0] pins_w;
  logic scl_q_r, sda_q_r, cs_q_r;
  logic scl_rise, scl_fall, start_ev, stop_ev, cs_rise;
  qwud_sync #(.W(SYNC_W)) u_sync (
    .i_clk (i_sys_clk),
    .i_rst (i_rst),
    .i_d   ({i_addr_pin_2, i_addr_pin_1, i_addr_pin_0, i_wp_n, i_channel_sel_msb,
             i_channel_sel_lsb, i_updown, i_cs_n, i_sda, i_scl}),
    .o_q   (sy)
  );
  assign scl_s  = sy[0];
  assign sda_s  = sy[1];
  assign cs_s   = sy[2];
  assign up_s   = sy[3];
  assign sel_w  = sy[5:4];
  assign wp_s   = sy[6];
  assign pins_w = sy[9:7];
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      scl_q_r <= 1'b1;
      sda_q_r <= 1'b1;
      cs_q_r  <= 1'b1;
    end else begin
      scl_q_r <= scl_s;
      sda_q_r <= sda_s;
      cs_q_r  <= cs_s;
    end
  end
  assign scl_rise = scl_s & ~scl_q_r;
  assign scl_fall = ~scl_s & scl_q_r;
  assign start_ev = scl_s & scl_q_r & sda_q_r & ~sda_s;
  assign stop_ev  = scl_s & scl_q_r & ~sda_q_r & sda_s;
  assign cs_rise  = cs_s & ~cs_q_r;
  qwud_state_t st_r;
  logic [3:0]  bcnt_r;
  logic [7:0]  sh_r, tx_sh_r, reg_addr_r, tx_byte;
  logic [2:0]  sr_r;
  logic        rw_r, sda_oe_r, nv_pend_r;
  logic [BUSY_W-1:0] busy_cnt_r;
  logic        busy;
  logic [2:0]  rc_r;
  logic        done_r;
  logic [NUM_WIPERS-1:0][POS_W-1:0] pos_r;
  logic        mem_we;
  logic [MEM_AW-1:0] mem_addr;
  logic [POS_W-1:0]  mem_wdata, mem_rdata;
  logic        store_go, cnt_go, byte_done, wr_byte, dcp_hit, nv_sel, load_tx;
  logic        dr_wr, pos_i2c_we;
  logic [POS_W-1:0]  pos_i2c_val;
  assign busy      = busy_cnt_r != '0;
  assign nv_sel    = sr_r[SR_NV_BIT];
  assign dcp_hit   = reg_addr_r <= ADDR_DCP_LAST;
  assign byte_done = scl_fall && (bcnt_r == BYTE_BITS);
  assign wr_byte   = (st_r == S_WR) && byte_done;
  assign dr_wr     = done_r && wr_byte && nv_sel && dcp_hit && wp_s;
  assign load_tx   = scl_fall && (((st_r == S_DEVACK) && rw_r) || (st_r == S_RDACK));
  // Up/down stores ignore the row select bits and always use row zero.
  assign store_go  = done_r && cs_rise && scl_s && wp_s && !busy;
  assign cnt_go    = done_r && !cs_s && scl_fall;
  // ==========================================================================
  // Saved register storage and port arbitration
  always_comb begin
    mem_we    = 1'b0;
    mem_addr  = {reg_addr_r[1:0], sr_r[SR_ROW_HI:SR_ROW_LO]};
    mem_wdata = sh_r;
    if (!done_r) begin
      mem_addr = {rc_r[1:0], ROW_DEF};
    end else if (store_go) begin
      mem_we    = 1'b1;
      mem_addr  = {sel_w, ROW_DEF};
      mem_wdata = pos_r[sel_w];
    end else if (dr_wr) begin
      mem_we = 1'b1;
    end
  end
  qwud_nvmem #(.DW(POS_W), .AW(MEM_AW), .INIT(MEM_INIT)) u_mem (
    .i_clk   (i_sys_clk),
    .i_we    (mem_we),
    .i_addr  (mem_addr),
    .i_wdata (mem_wdata),
    .o_rdata (mem_rdata)
  );
  // ==========================================================================
  // Power-up recall: one read per wiper, captured a cycle later
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      rc_r   <= '0;
      done_r <= 1'b0;
    end else if (!done_r) begin
      rc_r   <= rc_r + 3'h1;
      done_r <= rc_r == RECALL_END;
    end
  end
  // ==========================================================================
  // Wiper positions
  always_comb begin
    pos_i2c_we  = 1'b0;
    pos_i2c_val = sh_r;
    if (wr_byte && dcp_hit && (!nv_sel || dr_wr)) begin
      pos_i2c_we = 1'b1;
    end else if (load_tx && nv_sel && dcp_hit) begin
      pos_i2c_we  = 1'b1;
      pos_i2c_val = mem_rdata;
    end
  end
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      pos_r <= '0;
    end else if (!done_r) begin
      if (rc_r != '0) begin
        pos_r[2'(rc_r - 3'h1)] <= mem_rdata;
      end
    end else if (cnt_go) begin
      if (up_s && pos_r[sel_w] != POS_MAX) begin
        pos_r[sel_w] <= pos_r[sel_w] + POS_STEP;
      end else if (!up_s && pos_r[sel_w] != POS_MIN) begin
        pos_r[sel_w] <= pos_r[sel_w] - POS_STEP;
      end
    end else if (pos_i2c_we && done_r) begin
      pos_r[reg_addr_r[1:0]] <= pos_i2c_val;
    end
  end
  // ==========================================================================
  // Tap decode, registered so that switch enables never glitch
  for (genvar w = 0; w < NUM_WIPERS; w++) begin : g_tap
    always_ff @(posedge i_sys_clk or posedge i_rst) begin
      if (i_rst) begin
        o_tap_en[w] <= '0;
      end else begin
        o_tap_en[w] <= TAP_LOW << pos_r[w];
      end
    end
    a_tap_onehot: assert property (@(posedge i_sys_clk) disable iff (i_rst)
      done_r |=> $onehot(o_tap_en[w])) else $error("tap enables not one-hot");
    a_tap_low_end: assert property (@(posedge i_sys_clk) disable iff (i_rst)
      pos_r[w] == POS_MIN |=> o_tap_en[w][0]) else $error("zero does not pick low tap");
  end
  // ==========================================================================
  // Self-timed nonvolatile write
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      busy_cnt_r <= '0;
      nv_pend_r  <= 1'b0;
    end else if ((cs_s && stop_ev && nv_pend_r) || store_go) begin
      busy_cnt_r <= BUSY_W'(P_NV_WRITE_CYC);
      nv_pend_r  <= 1'b0;
    end else begin
      busy_cnt_r <= busy ? busy_cnt_r - 1'b1 : busy_cnt_r;
      nv_pend_r  <= nv_pend_r | dr_wr;
    end
  end
  // ==========================================================================
  // Two-wire slave
  assign tx_byte = (reg_addr_r == ADDR_STATUS) ? {5'h00, sr_r} :
                   !dcp_hit ? 8'h00 : nv_sel ? mem_rdata : pos_r[reg_addr_r[1:0]];
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      st_r       <= S_IDLE;
      bcnt_r     <= '0;
      sh_r       <= '0;
      tx_sh_r    <= '0;
      reg_addr_r <= '0;
      sr_r       <= SR_RESET;
      rw_r       <= 1'b0;
      sda_oe_r   <= 1'b0;
    end else if (!cs_s) begin
      st_r     <= S_IDLE;
      sda_oe_r <= 1'b0;
    end else if (start_ev) begin
      st_r     <= S_DEV;
      bcnt_r   <= '0;
      sda_oe_r <= 1'b0;
    end else if (stop_ev) begin
      st_r     <= S_IDLE;
      sda_oe_r <= 1'b0;
    end else begin
      case (st_r)
        S_DEV, S_REG, S_WR: begin
          if (scl_rise) begin
            sh_r   <= {sh_r[6:0], sda_s};
            bcnt_r <= bcnt_r + 4'h1;
          end else if (byte_done) begin
            bcnt_r <= '0;
            if (st_r == S_REG) begin
              reg_addr_r <= sh_r;
              sda_oe_r   <= 1'b1;
              st_r       <= S_REGACK;
            end else if (st_r == S_WR) begin
              if (reg_addr_r == ADDR_STATUS) begin
                sr_r <= sh_r[2:0];
              end
              sda_oe_r <= 1'b1;
              st_r     <= S_WRACK;
            end else if (sh_r[7:4] == P_TYPE_ID && sh_r[3:1] == pins_w && !busy) begin
              rw_r     <= sh_r[0];
              sda_oe_r <= 1'b1;
              st_r     <= S_DEVACK;
            end else begin
              st_r <= S_IDLE;
            end
          end
        end
        S_DEVACK, S_RDACK: begin
          if (st_r == S_RDACK && scl_rise && sda_s) begin
            st_r <= S_IDLE;
          end else if (load_tx) begin
            sda_oe_r <= ~tx_byte[7];
            tx_sh_r  <= {tx_byte[6:0], 1'b0};
            bcnt_r   <= '0;
            st_r     <= S_RD;
          end else if (scl_fall) begin
            sda_oe_r <= 1'b0;
            st_r     <= S_REG;
          end
        end
        S_REGACK, S_WRACK: begin
          if (scl_fall) begin
            sda_oe_r <= 1'b0;
            st_r     <= S_WR;
          end
        end
        S_RD: begin
          if (scl_rise) begin
            bcnt_r <= bcnt_r + 4'h1;
          end else if (byte_done) begin
            sda_oe_r <= 1'b0;
            bcnt_r   <= '0;
            st_r     <= S_RDACK;
          end else if (scl_fall) begin
            sda_oe_r <= ~tx_sh_r[7];
            tx_sh_r  <= {tx_sh_r[6:0], 1'b0};
          end
        end
        default: begin
          st_r <= S_IDLE;
        end
      endcase
    end
  end
  // ==========================================================================
  // Output flops; the data pin only ever pulls low.
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      o_sda_out <= 1'b0;
      o_sda_oe  <= 1'b0;
      o_nv_busy <= 1'b0;
    end else begin
      o_sda_out <= 1'b0;
      o_sda_oe  <= sda_oe_r;
      o_nv_busy <= busy;
    end
  end
  // ==========================================================================
  // Checks; the helper flops need no reset because the checks are off in reset.
  logic [1:0]       sel_q_r;
  logic [POS_W-1:0] old_q_r;
  always_ff @(posedge i_sys_clk) begin
    sel_q_r <= sel_w;
    old_q_r <= pos_r[sel_w];
  end
  sequence s_count_up;
    cnt_go && up_s && pos_r[sel_w] != POS_MAX;
  endsequence
  sequence s_store_req;
    done_r && cs_rise && scl_s && wp_s && !busy;
  endsequence
  a_count_up: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    s_count_up |=> pos_r[sel_q_r] == old_q_r + POS_STEP) else $error("count up failed");
  a_count_sat: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    cnt_go && up_s && pos_r[sel_w] == POS_MAX |=> pos_r[sel_q_r] == POS_MAX)
    else $error("counter wrapped");
  a_store_write: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    s_store_req |-> mem_we && mem_addr == {sel_w, ROW_DEF} && mem_wdata == pos_r[sel_w] ##1 busy)
    else $error("store not performed");
  a_store_blocked: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    cs_rise && (!scl_s || !wp_s) |-> !mem_we) else $error("unwanted store");
  a_cs_ignore: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    !cs_s |=> st_r == S_IDLE ##1 !o_sda_oe) else $error("bus active under chip select");
  a_busy_nack: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    cs_s && st_r == S_DEV && byte_done && busy && !start_ev && !stop_ev |=> st_r == S_IDLE)
    else $error("address acked while busy");
  a_start_seen: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    cs_s && start_ev |=> st_r == S_DEV && !sda_oe_r) else $error("start missed");
  a_recall_done: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    !done_r |-> ##[1:5] done_r) else $error("recall too slow");
endmodule // qwud_top

/* sim/qwud_host_model.sv */
module qwud_host_model (
  input  wire logic i_clk,
  input  wire logic i_sda_out,
  input  wire logic i_sda_oe,
  output logic      o_scl,
  output logic      o_sda,
  output logic      o_cs_n,
  output logic      o_updown,
  output logic      o_chan_lsb,
  output logic      o_chan_msb
);
  timeunit 1ns;
  timeprecision 100ps;

  logic sda_m;

  // Open drain with a pull-up: the wire is low if either party pulls it.
  assign o_sda = sda_m & (i_sda_oe ? i_sda_out : 1'b1);

  initial begin
    o_scl = 1'b1;
    sda_m = 1'b1;
    o_cs_n = 1'b1;
    o_updown = 1'b0;
    o_chan_lsb = 1'b0;
    o_chan_msb = 1'b0;
  end

  // ==========================================================================
  // Pin timing, one half period of the 160 ns link clock
  task automatic hp();
    repeat (20) @(negedge i_clk);
  endtask

  // Data moves only well after the clock falls, so it never looks like a frame edge.
  task automatic clk_bit(input logic b, output logic seen);
    sda_m = b;
    hp();
    o_scl = 1'b1;
    hp();
    seen = o_sda;
    o_scl = 1'b0;
    hp();
  endtask

  task automatic start();
    sda_m = 1'b1;
    hp();
    o_scl = 1'b1;
    hp();
    sda_m = 1'b0;
    hp();
    o_scl = 1'b0;
    hp();
  endtask

  task automatic stop();
    sda_m = 1'b0;
    hp();
    o_scl = 1'b1;
    hp();
    sda_m = 1'b1;
    hp();
  endtask

  task automatic send_byte(input logic [7:0] d, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) clk_bit(d[i], s);
    clk_bit(1'b1, s);
    ack = ~s;
  endtask

  task automatic recv_byte(input logic mack, output logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--) clk_bit(1'b1, d[i]);
    clk_bit(~mack, s);
  endtask

  // ==========================================================================
  // Up/down pins
  task automatic sel_pins(input logic cs_n, input logic [1:0] w, input logic up);
    o_chan_msb = w[1];
    o_chan_lsb = w[0];
    o_updown = up;
    hp();
    o_cs_n = cs_n;
    hp();
  endtask

  // Stores ignore the status row bits, so a store always targets row zero.
  task automatic updown(input logic [1:0] w, input logic up, input int n, input logic scl_end);
    sel_pins(1'b0, w, up);
    repeat (n) begin
      o_scl = 1'b1;
      hp();
      o_scl = 1'b0;
      hp();
    end
    o_scl = scl_end;
    hp();
    sel_pins(1'b1, w, up);
    o_scl = 1'b1;
    hp();
  endtask
endmodule // qwud_host_model

/* sim/qwud_top_tb.sv */
module qwud_top_tb import qwud_pkg::*; ;
  timeunit 1ns;
  timeprecision 100ps;

  localparam int unsigned NVCYC = 3000;
  typedef struct {string nm; int sel; logic [8:0] v;} qwud_note_t;

  logic clk, rst, scl, sda, sda_out, sda_oe, cs_n, updown, c_lsb, c_msb, wp_n, busy, ack_r;
  logic [NUM_WIPERS-1:0][NUM_TAPS-1:0] tap_en;
  logic [2:0] apins;
  logic [7:0] rx_r;
  logic [7:0] pos [4];
  qwud_note_t notes[$];
  int n_errors = 0;
  int check_count = 0;

  qwud_top #(.P_NV_WRITE_CYC(NVCYC)) u_dut (
    .i_sys_clk(clk), .i_rst(rst), .i_cs_n(cs_n), .i_scl(scl), .i_sda(sda),
    .o_sda_out(sda_out), .o_sda_oe(sda_oe), .i_updown(updown),
    .i_channel_sel_lsb(c_lsb), .i_channel_sel_msb(c_msb), .i_wp_n(wp_n),
    .i_addr_pin_0(apins[0]), .i_addr_pin_1(apins[1]), .i_addr_pin_2(apins[2]),
    .o_tap_en(tap_en), .o_nv_busy(busy));

  qwud_host_model u_host (
    .i_clk(clk), .i_sda_out(sda_out), .i_sda_oe(sda_oe), .o_scl(scl), .o_sda(sda),
    .o_cs_n(cs_n), .o_updown(updown), .o_chan_lsb(c_lsb), .o_chan_msb(c_msb));

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  // ==========================================================================
  // Expectations and the monitor that settles them
  function automatic logic [8:0] tap_pos(input logic [NUM_TAPS-1:0] t);
    logic [8:0] p;
    int c;
    p = 9'h1FF;
    c = 0;
    for (int i = 0; i < NUM_TAPS; i++) begin
      if (t[i] === 1'b1) begin
        c++;
        p = 9'(i);
      end else if (t[i] !== 1'b0) c += 2;
    end
    return (c == 1) ? p : 9'h1FF;
  endfunction

  task automatic note(input string nm, input int sel, input logic [8:0] v);
    notes.push_back('{nm, sel, v});
  endtask

  initial begin : monitor
    qwud_note_t nt;
    logic [8:0] seen;
    forever begin
      @(negedge clk);
      #1;
      while (notes.size() > 0) begin
        nt = notes.pop_front();
        case (nt.sel)
          4: seen = {8'h00, busy};
          5: seen = {8'h00, ack_r};
          6: seen = {1'b0, rx_r};
          7: seen = {8'h00, sda_oe};
          default: seen = tap_pos(tap_en[nt.sel]);
        endcase
        check_count++;
        if (seen !== nt.v) begin
          n_errors++;
          $display("Error %s expected %h seen %h", nt.nm, nt.v, seen);
        end
      end
    end
  end

  // ==========================================================================
  // Bus sequences
  task automatic power_up();
    rst = 1'b1;
    repeat (6) @(negedge clk);
    rst = 1'b0;
    repeat (20) @(negedge clk);
  endtask

  task automatic wr(input logic [7:0] sa, input logic [7:0] ra, input logic [7:0] d);
    u_host.start();
    u_host.send_byte(sa, ack_r);
    if (ack_r === 1'b1) begin
      u_host.send_byte(ra, ack_r);
      u_host.send_byte(d, ack_r);
    end
    u_host.stop();
  endtask

  task automatic rd(input logic [7:0] ra, input logic mack);
    logic a;
    u_host.start();
    u_host.send_byte({TYPE_ID_DEF, apins, 1'b0}, a);
    u_host.send_byte(ra, a);
    u_host.start();
    u_host.send_byte({TYPE_ID_DEF, apins, 1'b1}, ack_r);
    u_host.recv_byte(mack, rx_r);
  endtask

  task automatic poll();
    u_host.start();
    u_host.send_byte({TYPE_ID_DEF, apins, 1'($urandom_range(0, 1))}, ack_r);
    u_host.stop();
  endtask

  // Bounded wait for the internal write to finish before the next saved access.
  task automatic wait_idle();
    for (int k = 0; k < 20000 && busy !== 1'b0; k++) @(negedge clk);
  endtask

  task automatic wrap_up();
    $display("checks %0d errors %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  initial begin : watchdog
    #400000;
    n_errors++;
    $display("Error watchdog expected finish seen timeout");
    wrap_up();
  end

  // ==========================================================================
  // Tests
  initial begin : main
    int n;
    logic [7:0] d;
    rst = 1'b1;
    wp_n = 1'b1;
    n = $urandom(32'h2318);
    apins = 3'($urandom_range(0, 7));
    power_up();
    for (int w = 0; w < 4; w++) note("tap", w, 9'h000);
    note("sda_oe", 7, 9'h000);
    $display("test power_up done");
    for (int w = 0; w < 4; w++) begin
      n = $urandom_range(1, 40);
      u_host.updown(2'(w), 1'b1, n, 1'b0);
      note("tap", w, 9'(n));
      u_host.updown(2'(w), 1'b0, n + 3, 1'b0);
      note("tap", w, 9'h000);
      u_host.updown(2'(w), 1'b1, n, 1'b0);
      pos[w] = 8'(n);
    end
    for (int w = 0; w < 4; w++) note("tap", w, {1'b0, pos[w]});
    u_host.updown(2'h3, 1'b1, 260, 1'b0);
    note("tap", 3, 9'h0FF);
    $display("test updown done");
    wp_n = 1'b0;
    u_host.updown(2'h0, 1'b1, 1, 1'b1);
    note("nv_busy", 4, 9'h000);
    wp_n = 1'b1;
    u_host.updown(2'h0, 1'b1, 1, 1'b0);
    note("nv_busy", 4, 9'h000);
    u_host.updown(2'h0, 1'b1, 1, 1'b1);
    note("nv_busy", 4, 9'h001);
    poll();
    note("ack", 5, 9'h000);
    wait_idle();
    poll();
    note("ack", 5, 9'h001);
    power_up();
    note("tap", 0, {1'b0, pos[0] + 8'h03});
    note("tap", 3, 9'h000);
    $display("test store done");
    wr({~TYPE_ID_DEF, apins, 1'b0}, 8'h01, 8'h55);
    note("ack", 5, 9'h000);
    wr({TYPE_ID_DEF, ~apins, 1'b0}, 8'h01, 8'h55);
    note("ack", 5, 9'h000);
    d = 8'($urandom_range(1, 254));
    wr({TYPE_ID_DEF, apins, 1'b0}, 8'h01, d);
    note("ack", 5, 9'h001);
    note("tap", 1, {1'b0, d});
    rd(8'h07, 1'b0);
    u_host.stop();
    note("status", 6, 9'h000);
    rd(8'h01, 1'b1);
    note("rd_byte", 6, {1'b0, d});
    u_host.recv_byte(1'b0, rx_r);
    u_host.stop();
    note("rd_byte", 6, {1'b0, d});
    $display("test twowire done");
    wp_n = 1'b0;
    u_host.sel_pins(1'b0, 2'h3, 1'b1);
    wr({TYPE_ID_DEF, apins, 1'b0}, 8'h01, 8'h11);
    note("ack", 5, 9'h000);
    note("tap", 1, {1'b0, d});
    u_host.sel_pins(1'b1, 2'h3, 1'b1);
    wp_n = 1'b1;
    d = 8'($urandom_range(1, 254));
    wr({TYPE_ID_DEF, apins, 1'b0}, 8'h07, 8'h01);
    wr({TYPE_ID_DEF, apins, 1'b0}, 8'h02, d);
    note("nv_busy", 4, 9'h001);
    poll();
    note("ack", 5, 9'h000);
    wait_idle();
    power_up();
    note("tap", 2, {1'b0, d});
    $display("test saved_write done");
    repeat (10) @(negedge clk);
    wrap_up();
  end
endmodule // qwud_top_tb
